/* File: scr_map.vh */
/*
  Register indices, reset values and timing counts of the serial channel
  reset and power-mode register bank.
  Assumes inclusion by bare name from the bank's modules.
*/
`ifndef SCR_MAP_VH
`define SCR_MAP_VH

// ==========================================================================
// Register indices.
`define SCR_IDX_CONFIG_0      5'h00
`define SCR_IDX_CONFIG_1      5'h01
`define SCR_IDX_CONFIG_2      5'h02
`define SCR_IDX_IRQ_MASK_A    5'h03
`define SCR_IDX_IRQ_MASK_B    5'h04
`define SCR_IDX_PORT_MASK     5'h05
`define SCR_IDX_IRQ_PORT_CFG  5'h06
`define SCR_IDX_PORT_DIR      5'h07
`define SCR_IDX_VECTOR_BASE   5'h08
`define SCR_IDX_PREAMBLE      5'h09
`define SCR_IDX_TX_CNT_HIGH   5'h0A
`define SCR_IDX_STATUS        5'h0B
`define SCR_IDX_ADDR_MASK_LO  5'h0C
`define SCR_IDX_ADDR_MASK_HI  5'h0D
`define SCR_IDX_TX_SLOT       5'h0E
`define SCR_IDX_RX_SLOT       5'h0F
`define SCR_IDX_TX_CAP        5'h10
`define SCR_IDX_RX_CAP        5'h11
`define SCR_IDX_IRQ_SRC       5'h12
`define SCR_NUM_REGS          18

// ==========================================================================
// Reset values.
`define SCR_RST_ZERO          8'h00
`define SCR_RST_MASK          8'hFF
`define SCR_RST_PORT_DIR      8'hFF
`define SCR_RST_STATUS        8'h48

// ==========================================================================
// Field positions.
`define SCR_BIT_POWER_UP      7
`define SCR_BIT_TX_FIFO_WR    6
`define SCR_BIT_RX_LINE_ACT   3
`define SCR_BIT_CMD_BUSY      2

// ==========================================================================
// Timing: least reset hold in ns and the clock period in ns.
`define SCR_RESET_MIN_NS      5000
`define SCR_CLK_PERIOD_NS     5
`define SCR_RESET_MIN_CYC     ((`SCR_RESET_MIN_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)

`endif

/* File: scr_reg_mem.v */
/*
  Small register memory for the bank: one write port and one registered
  read port, with a reset loading every word from the scr_default function.
  Assumes one clock and an asynchronous active-low reset.
*/
`include "scr_map.vh"

module scr_reg_mem (
  input  wire         clock_i,
  input  wire         rst_b_i,
  input  wire         wr_en_i,
  input  wire [4:0]   wr_idx_i,
  input  wire [7:0]   wr_data_i,
  input  wire [4:0]   rd_idx_i,
  output reg  [7:0]   rd_data_o,
  output wire [143:0] all_o
);

  reg [7:0] mem_r [0:`SCR_NUM_REGS-1];

  // ========================================================================
  // Reset defaults.
  function [7:0] scr_default;
    input integer idx;
    begin
      if (idx == `SCR_IDX_IRQ_MASK_A || idx == `SCR_IDX_IRQ_MASK_B ||
          idx == `SCR_IDX_PORT_MASK) begin
        scr_default = `SCR_RST_MASK;
      end else if (idx == `SCR_IDX_PORT_DIR) begin
        scr_default = `SCR_RST_PORT_DIR;
      end else begin
        scr_default = `SCR_RST_ZERO;
      end
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `SCR_NUM_REGS; g = g + 1) begin : g_word
      always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mem_r[g] <= scr_default(g);
        end else if (wr_en_i && wr_idx_i == g) begin
          mem_r[g] <= wr_data_i;
        end
      end
      assign all_o[g*8 +: 8] = mem_r[g];
    end
  endgenerate

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_idx_i < `SCR_NUM_REGS) begin
      rd_data_o <= mem_r[rd_idx_i];
    end else begin
      rd_data_o <= 8'h00;
    end
  end

endmodule

/* File: scr_bank.v */
/*
  Reset-default and power-mode register bank of one serial channel.
  Assumes a host on a plain strobe port in the same clock domain and
  asynchronous pins (reset input, port interrupts) from outside it.
*/
// Added by the designer: the address-and-strobe port and the register offsets.
`include "scr_map.vh"


module scr_bank (
  input  wire       clock_i,
  input  wire       rst_b_i,
  input  wire       reset_input_i,
  input  wire [4:0] addr_i,
  input  wire [7:0] wr_data_i,
  input  wire       wr_i,
  input  wire       rd_i,
  output wire [7:0] rd_data_o,
  input  wire [7:0] chan_irq_i,
  input  wire [7:0] port_irq_i,
  input  wire       tx_fifo_full_i,
  input  wire       rx_line_active_i,
  input  wire       cmd_busy_i,
  output reg        chan_clk_en_o,
  output reg        osc_en_o,
  output reg        irq_o,
  output reg  [7:0] port_direction_o,
  output reg  [7:0] vector_base_o,
  output reg  [7:0] irq_port_config_o
);

  parameter RESET_HOLD_CYC = `SCR_RESET_MIN_CYC;

  // ========================================================================
  // Input synchronisers.
  reg        res_s1_r;
  reg        res_s2_r;
  reg [7:0]  chi_s1_r;
  reg [7:0]  chi_s2_r;
  reg [7:0]  pti_s1_r;
  reg [7:0]  pti_s2_r;
  reg [2:0]  st_s1_r;
  reg [2:0]  st_s2_r;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_s1_r <= 1'b0;
      res_s2_r <= 1'b0;
      chi_s1_r <= 8'h00;
      chi_s2_r <= 8'h00;
      pti_s1_r <= 8'h00;
      pti_s2_r <= 8'h00;
      st_s1_r  <= 3'h0;
      st_s2_r  <= 3'h0;
    end else begin
      res_s1_r <= reset_input_i;
      res_s2_r <= res_s1_r;
      chi_s1_r <= chan_irq_i;
      chi_s2_r <= chi_s1_r;
      pti_s1_r <= port_irq_i;
      pti_s2_r <= pti_s1_r;
      st_s1_r  <= {tx_fifo_full_i, rx_line_active_i, cmd_busy_i};
      st_s2_r  <= st_s1_r;
    end
  end

  // ========================================================================
  // Reset input hold filter.
  reg [15:0] hold_cnt_r;
  reg [15:0] hold_cnt_nxt;
  reg        soft_rst_r;
  reg        soft_rst_nxt;

  always @* begin
    hold_cnt_nxt = hold_cnt_r;
    soft_rst_nxt = 1'b0;
    if (!res_s2_r) begin
      hold_cnt_nxt = 16'h0000;
    end else if (hold_cnt_r >= RESET_HOLD_CYC[15:0] - 16'h0001) begin
      soft_rst_nxt = 1'b1;
    end else begin
      hold_cnt_nxt = hold_cnt_r + 16'h0001;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt_r <= 16'h0000;
      soft_rst_r <= 1'b0;
    end else begin
      hold_cnt_r <= hold_cnt_nxt;
      soft_rst_r <= soft_rst_nxt;
    end
  end

  // Registers return to defaults on either reset source.
  reg bank_rst_b_r;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bank_rst_b_r <= 1'b0;
    end else begin
      bank_rst_b_r <= ~soft_rst_r;
    end
  end

  wire bank_rst_b = rst_b_i & bank_rst_b_r;

  // ========================================================================
  // Register storage.
  wire [143:0] all_regs;
  wire [7:0]   mem_rd_data;
  wire         mem_wr;

  assign mem_wr = wr_i && bank_rst_b_r && addr_i != `SCR_IDX_STATUS &&
                  addr_i != `SCR_IDX_IRQ_SRC;

  scr_reg_mem u_mem (
    .clock_i   (clock_i),
    .rst_b_i   (bank_rst_b),
    .wr_en_i   (mem_wr),
    .wr_idx_i  (addr_i),
    .wr_data_i (wr_data_i),
    .rd_idx_i  (addr_i),
    .rd_data_o (mem_rd_data),
    .all_o     (all_regs)
  );

  function [7:0] reg_at;
    input [143:0] v;
    input [4:0]   idx;
    begin
      reg_at = v[idx*8 +: 8];
    end
  endfunction

  wire [7:0] chan_config_0   = reg_at(all_regs, `SCR_IDX_CONFIG_0);
  wire [7:0] chan_irq_mask_a = reg_at(all_regs, `SCR_IDX_IRQ_MASK_A);
  wire [7:0] chan_irq_mask_b = reg_at(all_regs, `SCR_IDX_IRQ_MASK_B);
  wire [7:0] port_irq_mask   = reg_at(all_regs, `SCR_IDX_PORT_MASK);
  wire       power_up_bit    = chan_config_0[`SCR_BIT_POWER_UP];

  // ========================================================================
  // Live status: 48 hex after reset with idle inputs.
  reg [7:0] channel_status;

  always @* begin
    channel_status = `SCR_RST_STATUS;
    channel_status[`SCR_BIT_TX_FIFO_WR]  = ~st_s2_r[2];
    channel_status[`SCR_BIT_RX_LINE_ACT] = ~st_s2_r[1];
    channel_status[`SCR_BIT_CMD_BUSY]    = st_s2_r[0];
  end

  // ========================================================================
  // Read path with status and pending interrupt sources.
  reg       rd_sel_status_r;
  reg       rd_sel_irq_r;
  reg [7:0] status_cap_r;
  reg [7:0] irq_src_cap_r;
  wire [7:0] chan_pend = chi_s2_r & ~(chan_irq_mask_a & chan_irq_mask_b);
  wire [7:0] port_pend = pti_s2_r & ~port_irq_mask;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_sel_status_r <= 1'b0;
      rd_sel_irq_r    <= 1'b0;
      status_cap_r    <= `SCR_RST_STATUS;
      irq_src_cap_r   <= 8'h00;
    end else begin
      rd_sel_status_r <= rd_i && addr_i == `SCR_IDX_STATUS;
      rd_sel_irq_r    <= rd_i && addr_i == `SCR_IDX_IRQ_SRC;
      status_cap_r    <= channel_status;
      irq_src_cap_r   <= {4'h0, |port_pend, |chan_pend, 1'b0, power_up_bit};
    end
  end

  assign rd_data_o = rd_sel_status_r ? status_cap_r :
                     rd_sel_irq_r    ? irq_src_cap_r : mem_rd_data;

  // ========================================================================
  // Power mode, clocks and interrupt forwarding.
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      chan_clk_en_o     <= 1'b0;
      osc_en_o          <= 1'b0;
      irq_o             <= 1'b0;
      port_direction_o  <= `SCR_RST_PORT_DIR;
      vector_base_o     <= `SCR_RST_ZERO;
      irq_port_config_o <= `SCR_RST_ZERO;
    end else begin
      chan_clk_en_o     <= power_up_bit && bank_rst_b_r;
      osc_en_o          <= power_up_bit && bank_rst_b_r;
      irq_o             <= (power_up_bit && |chan_pend) || |port_pend;
      port_direction_o  <= reg_at(all_regs, `SCR_IDX_PORT_DIR);
      vector_base_o     <= reg_at(all_regs, `SCR_IDX_VECTOR_BASE);
      irq_port_config_o <= reg_at(all_regs, `SCR_IDX_IRQ_PORT_CFG);
    end
  end

  // Toggling the power-up bit touches the clock and oscillator enables, channel interrupt forwarding to irq_o and bit 0 of the interrupt source read.
  // Other defaults: masks preamble count high address masks
  // slots and capacity all loaded by the memory reset.

endmodule

/* File: scr_bank_asserts.sv */
/* Checker of the channel bank port behaviour.
   Assumes a bench that sets a short reset pin count. */
module scr_bank_asserts #(parameter RESET_HOLD_CYC = 4) (
  input wire       clock_i,
  input wire       rst_b_i,
  input wire       reset_input_i,
  input wire [4:0] addr_i,
  input wire [7:0] wr_data_i,
  input wire       wr_i,
  input wire [7:0] port_irq_i,
  input wire       chan_clk_en_o,
  input wire       osc_en_o,
  input wire       irq_o,
  input wire [7:0] port_direction_o,
  input wire [7:0] vector_base_o,
  input wire [7:0] irq_port_config_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // Properties.
  property p_osc; chan_clk_en_o == osc_en_o; endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable differs");
  property p_pu;
    wr_i && addr_i == 5'h00 && !reset_input_i |-> ##2 chan_clk_en_o == $past(wr_data_i[7], 2);
  endproperty
  a_pu: assert property (p_pu) else $error("power bit not applied");
  property p_irq; (!chan_clk_en_o && port_irq_i == 8'h00) [*6] |-> !irq_o; endproperty
  a_irq: assert property (p_irq) else $error("interrupt while powered down");
  property p_dir; $rose(rst_b_i) |-> port_direction_o == 8'hFF; endproperty
  a_dir: assert property (p_dir) else $error("port direction reset wrong");
  property p_vec; $rose(rst_b_i) |-> vector_base_o == 8'h00; endproperty
  a_vec: assert property (p_vec) else $error("vector base reset wrong");
  property p_ipc; $rose(rst_b_i) |-> irq_port_config_o == 8'h00 && !chan_clk_en_o; endproperty
  a_ipc: assert property (p_ipc) else $error("irq port config reset wrong");
  property p_keep;
    disable iff (!rst_b_i || reset_input_i)
    $past(!wr_i) && $past(!wr_i, 2) |-> $stable(vector_base_o) && $stable(irq_port_config_o);
  endproperty
  a_keep: assert property (p_keep) else $error("register changed without write");
  property p_pin;
    reset_input_i [*8] ##1 reset_input_i [*8] |-> !chan_clk_en_o && port_direction_o == 8'hFF;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin did not reset");
endmodule

bind scr_bank scr_bank_asserts #(.RESET_HOLD_CYC(RESET_HOLD_CYC)) i_chk (.clock_i, .rst_b_i,
  .reset_input_i, .addr_i, .wr_data_i, .wr_i, .port_irq_i, .chan_clk_en_o, .osc_en_o, .irq_o,
  .port_direction_o, .vector_base_o, .irq_port_config_o);

/* File: scr_host.sv */
/* Host processor model on the bank strobe port.
   Assumes the bench calls its tasks one at a time. */
module scr_host (
  input  wire  logic       clock_i,
  input  wire  logic [7:0] rd_data_i,
  output logic       [4:0] addr_o,
  output logic       [7:0] wr_data_o,
  output logic             wr_o,
  output logic             rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr_o, wr_data_o, wr_o, rd_o} = 15'h0000;
  // ==========================================================
  // Bus cycles; address and data are scrambled once released.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    {addr_o, wr_data_o, wr_o} <= {a, d, 1'b1};
    @(posedge clock_i);
    {addr_o, wr_data_o, wr_o} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock_i);
    {addr_o, rd_o} <= {a, 1'b1};
    @(posedge clock_i);
    {addr_o, rd_o} <= {~a, 1'b0};
    @(negedge clock_i);
    d = rd_data_i;
  endtask
  // Mode and clock setup come first, while still powered down.
  task automatic start(input logic [7:0] mode);
    wr(5'h00, 8'h00);
    wr(5'h01, mode);
  endtask
  task automatic pw(input logic on);
    wr(5'h00, {on, 7'h00});
  endtask
endmodule

/* File: scr_bank_tb_top.sv */
/* Self-checking bench of the channel bank.
   Assumes the host model and the bound checker. */
module scr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock_i = 1'b0, rst_b_i = 1'b0, reset_input_i = 1'b0;
  logic       tx_fifo_full_i = 1'b0, rx_line_active_i = 1'b0, cmd_busy_i = 1'b0;
  logic [7:0] chan_irq_i = 8'h00, port_irq_i = 8'h00, wr_data_i, rd_data_o, d;
  logic [7:0] port_direction_o, vector_base_o, irq_port_config_o, v [0:17];
  logic [4:0] addr_i;
  logic       wr_i, rd_i, chan_clk_en_o, osc_en_o, irq_o;
  integer     seed = 77, fail_count = 0, cmp_count = 0, i, p;
  always #2.5 clock_i = ~clock_i;
  scr_bank #(.RESET_HOLD_CYC(4)) i_dut (.clock_i, .rst_b_i, .reset_input_i, .addr_i,
    .wr_data_i, .wr_i, .rd_i, .rd_data_o, .chan_irq_i, .port_irq_i, .tx_fifo_full_i,
    .rx_line_active_i, .cmd_busy_i, .chan_clk_en_o, .osc_en_o, .irq_o, .port_direction_o,
    .vector_base_o, .irq_port_config_o);
  scr_host i_host (.clock_i, .rd_data_i(rd_data_o), .addr_o(addr_i), .wr_data_o(wr_data_i),
    .wr_o(wr_i), .rd_o(rd_i));
  // ==========================================================
  // Expectations, checks and closing.
  function automatic logic [7:0] exp_rst(input logic [4:0] a);
    exp_rst = (a inside {5'h03, 5'h04, 5'h05, 5'h07}) ? 8'hFF : (a == 5'h0B) ? 8'h48 : 8'h00;
  endfunction
  function automatic logic [7:0] exp_st(input logic [2:0] s);
    exp_st = {1'b0, ~s[2], 2'b00, ~s[1], s[0], 2'b00};
  endfunction
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
  endtask
  task automatic all_rst;
    for (int k = 0; k < 20; k++) rchk(k[4:0], exp_rst(k[4:0]));
    chk("clk_en", {7'h00, chan_clk_en_o}, 8'h00);
  endtask
  task automatic wirq(input logic e);
    int n;
    n = 0;
    #1;
    while (irq_o !== e && n < 20) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk("irq_o", {7'h00, irq_o}, {7'h00, e});
    if (n == 20) stop_test();
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    {chan_irq_i, port_irq_i} <= 16'hFFFF;
    all_rst();
    wirq(1'b0);
    $display("reset values done");
    for (i = 0; i < 8; i++) begin
      {tx_fifo_full_i, rx_line_active_i, cmd_busy_i} <= i[2:0];
      i_host.wr(5'h0B, 8'hFF);
      repeat (3) @(posedge clock_i);
      rchk(5'h0B, exp_st(i[2:0]));
    end
    {tx_fifo_full_i, rx_line_active_i, cmd_busy_i} <= 3'b000;
    $display("status done");
    v[1] = $random(seed);
    i_host.start(v[1]);
    for (i = 2; i < 18; i++) if (i != 11) begin
      v[i] = $random(seed);
      i_host.wr(i[4:0], v[i]);
    end
    for (p = 1; p >= 0; p--) begin
      i_host.pw(p[0]);
      @(posedge clock_i);
      #1;
      chk("clk_en", {7'h00, chan_clk_en_o}, {7'h00, p[0]});
      chk("vector", vector_base_o, v[8]);
      for (i = 1; i < 18; i++) if (i != 11) rchk(i[4:0], v[i]);
    end
    $display("power switching done");
    for (i = 3; i < 6; i++) i_host.wr(i[4:0], 8'h00);
    port_irq_i <= 8'h00;
    wirq(1'b0);
    port_irq_i <= 8'h01;
    wirq(1'b1);
    port_irq_i <= 8'h00;
    wirq(1'b0);
    i_host.pw(1'b1);
    wirq(1'b1);
    i_host.pw(1'b0);
    wirq(1'b0);
    chan_irq_i <= 8'h00;
    $display("interrupts done");
    reset_input_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    reset_input_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    all_rst();
    $display("reset pin done");
    stop_test();
  end
endmodule
